// File: core/uprd_regs.svh
// Register offsets, field positions and fixed values of the paged channel register decoder
`ifndef UPRD_REGS_SVH
`define UPRD_REGS_SVH
`define UPRD_OFS_0 3'h0
`define UPRD_OFS_1 3'h1
`define UPRD_OFS_2 3'h2
`define UPRD_OFS_3 3'h3
`define UPRD_OFS_4 3'h4
`define UPRD_OFS_5 3'h5
`define UPRD_OFS_6 3'h6
`define UPRD_OFS_7 3'h7
`define UPRD_EXT_KEY 8'hbf
`define UPRD_DIV_ACCESS_BIT 7
`define UPRD_PAGE2_BIT 6
`define UPRD_PAGE_SEL_FIXED 8'ha4
`define UPRD_AUTO_TOGGLE_MASK 8'hf3
`define UPRD_ADD_FEAT_MASK 8'h31
`define UPRD_RESEND_MASK 8'h03
`define UPRD_FLOW_TX_HW_BIT 5
`define UPRD_FLOW_TX_SW_BIT 4
`define UPRD_FLOW_RX_HW_BIT 1
`define UPRD_FLOW_RX_SW_BIT 0
`endif

// File: core/uprd_pkg.sv
// Types of the paged channel register decoder
package uprd_pkg;
    typedef enum logic [2:0] {PAGE_ZERO, PAGE_ONE, PAGE_TWO, PAGE_THREE, PAGE_FOUR} uprd_page_type;

    typedef struct packed {
        logic select;
        logic read;
        logic write;
        logic [2:0] address;
        logic [7:0] writeData;
    } uprd_bus_req_type;

    typedef struct packed {
        logic [7:0] rxBuffer;
        logic [7:0] interruptSource;
        logic [7:0] lineStatus;
        logic [7:0] modemStatus;
        logic [7:0] channelPending;
        logic [7:0] txCount;
        logic [7:0] rxCount;
        logic txHwFlow;
        logic txSwFlow;
        logic rxHwFlow;
        logic rxSwFlow;
    } uprd_status_type;

    typedef struct packed {
        logic [7:0] lineControl;
        logic [7:0] modemControl;
        logic [7:0] interruptEnables;
        logic [7:0] divisorLow;
        logic [7:0] divisorHigh;
        logic [7:0] scratchByte;
        logic [7:0] channelInterruptMask;
        logic pageSelect;
        logic [7:0] autoToggle;
        logic [7:0] enhancedFeatures;
        logic [7:0] resumeFirst;
        logic [7:0] resumeSecond;
        logic [7:0] pauseFirst;
        logic [7:0] pauseSecond;
        logic [7:0] additionalFeatures;
        logic [1:0] pauseResendCount;
        logic [7:0] txTrigger;
        logic [7:0] rxTrigger;
        logic [7:0] flowUpper;
        logic [7:0] flowLower;
    } uprd_ctrl_type;

    typedef struct packed {
        logic txHoldingWrite;
        logic fifoControlWrite;
        logic rxBufferRead;
        logic sourceRead;
        logic lineStatusRead;
        logic modemStatusRead;
        logic [7:0] data;
    } uprd_strobe_type;

    typedef struct packed {
        uprd_ctrl_type ctrl;
        uprd_strobe_type strobe;
        logic [7:0] readData;
    } uprd_state_type;
endpackage : uprd_pkg

// File: core/uprd_decoder.sv
// Paged register file and address decoder of one serial channel
`timescale 1ns/10ps
`include "uprd_regs.svh"
module uprd_decoder (
    input wire logic clk_sys,
    input wire logic reset,
    input wire uprd_pkg::uprd_bus_req_type hostReq,
    input wire uprd_pkg::uprd_status_type status,
    output logic [7:0] readData,
    output uprd_pkg::uprd_ctrl_type ctrlRegs,
    output uprd_pkg::uprd_strobe_type strobes
);
    import uprd_pkg::*;

    uprd_state_type state;
    uprd_state_type next_state;
    uprd_page_type curPage;

    // Extended key wins over the divisor bit; divisor bit wins over page two
    function automatic uprd_page_type decodePage(input logic [7:0] lineCtl,
                                                 input logic [7:0] modemCtl, input logic psel);
        uprd_page_type pg;
        if (lineCtl == `UPRD_EXT_KEY) begin
            pg = psel ? PAGE_FOUR : PAGE_THREE;
        end else if (lineCtl[`UPRD_DIV_ACCESS_BIT]) begin
            pg = PAGE_ONE;
        end else if (modemCtl[`UPRD_PAGE2_BIT]) begin
            pg = PAGE_TWO;
        end else begin
            pg = PAGE_ZERO;
        end
        return pg;
    endfunction : decodePage

    function automatic logic [7:0] flowByte(input uprd_status_type st);
        logic [7:0] fb;
        fb = 8'h00;
        fb[`UPRD_FLOW_TX_HW_BIT] = st.txHwFlow;
        fb[`UPRD_FLOW_TX_SW_BIT] = st.txSwFlow;
        fb[`UPRD_FLOW_RX_HW_BIT] = st.rxHwFlow;
        fb[`UPRD_FLOW_RX_SW_BIT] = st.rxSwFlow;
        return fb;
    endfunction : flowByte

    assign curPage = decodePage(state.ctrl.lineControl, state.ctrl.modemControl,
                                state.ctrl.pageSelect);

    always_comb begin
        logic doWrite;
        logic doRead;
        logic [7:0] wd;
        doWrite = hostReq.select && hostReq.write;
        doRead = hostReq.select && hostReq.read;
        wd = hostReq.writeData;
        next_state = state;
        next_state.strobe = '0;
        next_state.strobe.data = state.strobe.data;

        // Writes
        if (doWrite) begin
            if (hostReq.address == `UPRD_OFS_3) begin
                next_state.ctrl.lineControl = wd;
            end else begin
                case (curPage)
                    PAGE_ZERO, PAGE_ONE: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: begin
                                if (curPage == PAGE_ONE) begin
                                    next_state.ctrl.divisorLow = wd;
                                end else begin
                                    next_state.strobe.txHoldingWrite = 1'b1;
                                    next_state.strobe.data = wd;
                                end
                            end
                            `UPRD_OFS_1: begin
                                if (curPage == PAGE_ONE) begin
                                    next_state.ctrl.divisorHigh = wd;
                                end else begin
                                    next_state.ctrl.interruptEnables = wd;
                                end
                            end
                            `UPRD_OFS_2: begin
                                next_state.strobe.fifoControlWrite = 1'b1;
                                next_state.strobe.data = wd;
                            end
                            `UPRD_OFS_4: next_state.ctrl.modemControl = wd;
                            `UPRD_OFS_7: next_state.ctrl.scratchByte = wd;
                            default: begin
                            end
                        endcase
                    end
                    PAGE_TWO: begin
                        case (hostReq.address)
                            `UPRD_OFS_1: next_state.ctrl.channelInterruptMask = wd;
                            `UPRD_OFS_4: next_state.ctrl.modemControl = wd;
                            default: begin
                                // Offset 0 and the read-only offsets ignore writes
                            end
                        endcase
                    end
                    PAGE_THREE: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: next_state.ctrl.pageSelect = wd[0];
                            `UPRD_OFS_1: next_state.ctrl.autoToggle = wd & `UPRD_AUTO_TOGGLE_MASK;
                            `UPRD_OFS_2: next_state.ctrl.enhancedFeatures = wd;
                            `UPRD_OFS_4: next_state.ctrl.resumeFirst = wd;
                            `UPRD_OFS_5: next_state.ctrl.resumeSecond = wd;
                            `UPRD_OFS_6: next_state.ctrl.pauseFirst = wd;
                            `UPRD_OFS_7: next_state.ctrl.pauseSecond = wd;
                            default: begin
                            end
                        endcase
                    end
                    PAGE_FOUR: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: next_state.ctrl.pageSelect = wd[0];
                            `UPRD_OFS_1: next_state.ctrl.additionalFeatures = wd & `UPRD_ADD_FEAT_MASK;
                            `UPRD_OFS_2: next_state.ctrl.pauseResendCount = wd[1:0];
                            `UPRD_OFS_4: next_state.ctrl.txTrigger = wd;
                            `UPRD_OFS_5: next_state.ctrl.rxTrigger = wd;
                            `UPRD_OFS_6: next_state.ctrl.flowUpper = wd;
                            `UPRD_OFS_7: next_state.ctrl.flowLower = wd;
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Reads: data is registered and holds until the next read
        if (doRead) begin
            next_state.readData = 8'h00;
            if (hostReq.address == `UPRD_OFS_3) begin
                next_state.readData = state.ctrl.lineControl;
            end else begin
                case (curPage)
                    PAGE_ZERO, PAGE_ONE: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: begin
                                if (curPage == PAGE_ONE) begin
                                    next_state.readData = state.ctrl.divisorLow;
                                end else begin
                                    next_state.readData = status.rxBuffer;
                                    next_state.strobe.rxBufferRead = 1'b1;
                                end
                            end
                            `UPRD_OFS_1: begin
                                if (curPage == PAGE_ONE) begin
                                    next_state.readData = state.ctrl.divisorHigh;
                                end else begin
                                    next_state.readData = state.ctrl.interruptEnables;
                                end
                            end
                            `UPRD_OFS_2: begin
                                next_state.readData = status.interruptSource;
                                next_state.strobe.sourceRead = 1'b1;
                            end
                            `UPRD_OFS_4: next_state.readData = state.ctrl.modemControl;
                            `UPRD_OFS_5: begin
                                next_state.readData = status.lineStatus;
                                next_state.strobe.lineStatusRead = 1'b1;
                            end
                            `UPRD_OFS_6: begin
                                next_state.readData = status.modemStatus;
                                next_state.strobe.modemStatusRead = 1'b1;
                            end
                            `UPRD_OFS_7: next_state.readData = state.ctrl.scratchByte;
                            default: begin
                            end
                        endcase
                    end
                    PAGE_TWO: begin
                        case (hostReq.address)
                            `UPRD_OFS_2: next_state.readData = status.channelPending;
                            `UPRD_OFS_4: next_state.readData = state.ctrl.modemControl;
                            `UPRD_OFS_5: next_state.readData = status.txCount;
                            `UPRD_OFS_6: next_state.readData = status.rxCount;
                            `UPRD_OFS_7: next_state.readData = flowByte(status);
                            default: begin
                                // Offset 0 and the write-only mask read as zero
                            end
                        endcase
                    end
                    PAGE_THREE: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: next_state.readData =
                                `UPRD_PAGE_SEL_FIXED | {7'h00, state.ctrl.pageSelect};
                            `UPRD_OFS_1: next_state.readData = state.ctrl.autoToggle;
                            `UPRD_OFS_2: next_state.readData = state.ctrl.enhancedFeatures;
                            `UPRD_OFS_4: next_state.readData = state.ctrl.resumeFirst;
                            `UPRD_OFS_5: next_state.readData = state.ctrl.resumeSecond;
                            `UPRD_OFS_6: next_state.readData = state.ctrl.pauseFirst;
                            `UPRD_OFS_7: next_state.readData = state.ctrl.pauseSecond;
                            default: begin
                            end
                        endcase
                    end
                    PAGE_FOUR: begin
                        case (hostReq.address)
                            `UPRD_OFS_0: next_state.readData =
                                `UPRD_PAGE_SEL_FIXED | {7'h00, state.ctrl.pageSelect};
                            `UPRD_OFS_1: next_state.readData = state.ctrl.additionalFeatures;
                            `UPRD_OFS_2: next_state.readData = {6'h00, state.ctrl.pauseResendCount};
                            `UPRD_OFS_4: next_state.readData = state.ctrl.txTrigger;
                            `UPRD_OFS_5: next_state.readData = state.ctrl.rxTrigger;
                            `UPRD_OFS_6: next_state.readData = state.ctrl.flowUpper;
                            `UPRD_OFS_7: next_state.readData = state.ctrl.flowLower;
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign readData = state.readData;
    assign ctrlRegs = state.ctrl;
    assign strobes = state.strobe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic wrReq;
    logic rdReq;
    assign wrReq = hostReq.select && hostReq.write;
    assign rdReq = hostReq.select && hostReq.read;

    // Per-page request qualifiers keep the properties short
    logic [2:0] adr;
    logic [7:0] wdat;
    logic inZero;
    logic inOne;
    logic inTwo;
    logic inThree;
    logic inFour;
    assign adr = hostReq.address;
    assign wdat = hostReq.writeData;
    assign inZero = curPage == PAGE_ZERO;
    assign inOne = curPage == PAGE_ONE;
    assign inTwo = curPage == PAGE_TWO;
    assign inThree = curPage == PAGE_THREE;
    assign inFour = curPage == PAGE_FOUR;

    mask_write_a: assert property (wrReq && curPage == PAGE_TWO && hostReq.address == 3'h1
        |=> ctrlRegs.channelInterruptMask == $past(hostReq.writeData))
        else $error("channel mask not written");
    pending_read_a: assert property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h2
        |=> readData == $past(status.channelPending))
        else $error("pending byte wrong");
    tx_count_a: assert property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h5
        |=> readData == $past(status.txCount))
        else $error("transmit count wrong");
    rx_count_a: assert property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h6
        |=> readData == $past(status.rxCount))
        else $error("receive count wrong");
    flow_read_a: assert property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h7
        |=> readData[7:6] == 2'b00 && readData[3:2] == 2'b00
            && readData[5] == $past(status.txHwFlow) && readData[0] == $past(status.rxSwFlow)
            && readData[4] == $past(status.txSwFlow) && readData[1] == $past(status.rxHwFlow))
        else $error("flow state byte wrong");
    page_select_a: assert property (wrReq && adr == 3'h0
        && ctrlRegs.lineControl == 8'hbf
        |=> ctrlRegs.pageSelect == $past(wdat[0]))
        else $error("page select not applied");
    line_ctrl_a: assert property (wrReq && hostReq.address == 3'h3
        |=> ctrlRegs.lineControl == $past(hostReq.writeData))
        else $error("line control not written");
    page_two_zero_a: assert property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h0
        |=> readData == 8'h00)
        else $error("page two offset 0 not zero");
    holding_write_a: assert property (wrReq && curPage == PAGE_ZERO && hostReq.address == 3'h0
        |=> strobes.txHoldingWrite && strobes.data == $past(hostReq.writeData)
        ##1 !strobes.txHoldingWrite || $past(wrReq))
        else $error("holding write strobe wrong");
    divisor_low_a: assert property (wrReq && curPage == PAGE_ONE && hostReq.address == 3'h0
        |=> ctrlRegs.divisorLow == $past(hostReq.writeData) && !strobes.txHoldingWrite)
        else $error("divisor low not written");
    trigger_a: assert property (wrReq && curPage == PAGE_FOUR && hostReq.address == 3'h5
        |=> ctrlRegs.rxTrigger == $past(hostReq.writeData))
        else $error("receive trigger not written");

    // Page decode
    ext_page_a: assert property (ctrlRegs.lineControl == 8'hbf
        |-> curPage == (ctrlRegs.pageSelect ? PAGE_FOUR : PAGE_THREE))
        else $error("extended page wrong");
    page_two_sel_a: assert property (!ctrlRegs.lineControl[7]
        && ctrlRegs.modemControl[6] |-> inTwo)
        else $error("page two not selected");
    page_zero_sel_a: assert property (!ctrlRegs.lineControl[7]
        && !ctrlRegs.modemControl[6] |-> inZero)
        else $error("page zero not selected");
    page_one_sel_a: assert property (ctrlRegs.lineControl[7]
        && ctrlRegs.lineControl != 8'hbf |-> inOne)
        else $error("page one not selected");

    // Page two
    mask_read_zero_a: assert property (rdReq && inTwo && adr == 3'h1
        |=> readData == 8'h00)
        else $error("mask read not zero");
    page_two_none_a: assert property (wrReq && inTwo && adr == 3'h0
        |=> $stable(ctrlRegs) && !strobes.txHoldingWrite)
        else $error("offset 0 write acted");

    // Extended pages
    psel_read_a: assert property (rdReq && adr == 3'h0
        && ctrlRegs.lineControl == 8'hbf
        |=> readData == (`UPRD_PAGE_SEL_FIXED | {7'h00, $past(ctrlRegs.pageSelect)}))
        else $error("page select read wrong");
    toggle_write_a: assert property (wrReq && inThree && adr == 3'h1
        |=> ctrlRegs.autoToggle == ($past(wdat) & `UPRD_AUTO_TOGGLE_MASK))
        else $error("auto toggle wrong");
    feature_write_a: assert property (wrReq && inThree && adr == 3'h2
        |=> ctrlRegs.enhancedFeatures == $past(wdat))
        else $error("features wrong");
    resume_write_a: assert property (wrReq && inThree && adr == 3'h4
        |=> ctrlRegs.resumeFirst == $past(wdat))
        else $error("resume char wrong");
    pause_write_a: assert property (wrReq && inThree && adr == 3'h7
        |=> ctrlRegs.pauseSecond == $past(wdat))
        else $error("pause char wrong");
    pause_read_a: assert property (rdReq && inThree && adr == 3'h6
        |=> readData == $past(ctrlRegs.pauseFirst))
        else $error("pause char read wrong");
    add_feature_a: assert property (wrReq && inFour && adr == 3'h1
        |=> ctrlRegs.additionalFeatures == ($past(wdat) & `UPRD_ADD_FEAT_MASK))
        else $error("added features wrong");
    resend_read_a: assert property (rdReq && inFour && adr == 3'h2
        |=> readData[7:2] == 6'h00
            && readData[1:0] == $past(ctrlRegs.pauseResendCount))
        else $error("resend count wrong");
    tx_trigger_a: assert property (wrReq && inFour && adr == 3'h4
        |=> ctrlRegs.txTrigger == $past(wdat))
        else $error("tx trigger wrong");
    upper_thr_a: assert property (wrReq && inFour && adr == 3'h6
        |=> ctrlRegs.flowUpper == $past(wdat))
        else $error("upper threshold wrong");
    lower_read_a: assert property (rdReq && inFour && adr == 3'h7
        |=> readData == $past(ctrlRegs.flowLower))
        else $error("lower threshold wrong");

    // Common and legacy pages
    line_read_a: assert property (rdReq && adr == 3'h3
        |=> readData == $past(ctrlRegs.lineControl))
        else $error("line control read wrong");
    modem_write_a: assert property (wrReq && adr == 3'h4
        && !inThree && !inFour
        |=> ctrlRegs.modemControl == $past(wdat))
        else $error("modem control wrong");
    rx_buffer_a: assert property (rdReq && inZero && adr == 3'h0
        |=> readData == $past(status.rxBuffer) && strobes.rxBufferRead)
        else $error("rx buffer read wrong");
    divisor_high_a: assert property (wrReq && inOne && adr == 3'h1
        |=> ctrlRegs.divisorHigh == $past(wdat))
        else $error("divisor high wrong");

    mask_cov_c: cover property (wrReq && curPage == PAGE_TWO && hostReq.address == 3'h1);
    page_four_c: cover property (curPage == PAGE_THREE ##[1:20] curPage == PAGE_FOUR);
    pause_char_c: cover property (wrReq && curPage == PAGE_THREE && hostReq.address == 3'h7);
    flow_read_c: cover property (rdReq && curPage == PAGE_TWO && hostReq.address == 3'h7);
    ext_close_c: cover property (inFour ##[1:20] inZero);
endmodule : uprd_decoder

// File: dv/uprd_host_model.sv
// Host processor model that drives the channel register bus
`timescale 1ns/10ps
module uprd_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] readData,
    output uprd_pkg::uprd_bus_req_type hostReq
);
    import uprd_pkg::*;

    initial begin
        hostReq = '0;
    end

    // Released lines wander so a stale address or byte is never trusted
    task automatic release_bus();
        hostReq = '{1'b0, 1'b0, 1'b0, ~hostReq.address, ~hostReq.writeData};
    endtask : release_bus

    task automatic write_reg(input logic [2:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        hostReq = '{1'b1, 1'b0, 1'b1, addr, data};
        @(negedge clk_sys);
        release_bus();
    endtask : write_reg

    task automatic read_reg(input logic [2:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        hostReq = '{1'b1, 1'b1, 1'b0, addr, hostReq.writeData};
        @(negedge clk_sys);
        data = readData;
        release_bus();
    endtask : read_reg

    task automatic open_ext(input logic pageBit);
        write_reg(3'h3, 8'hbf);
        write_reg(3'h0, {7'h00, pageBit});
    endtask : open_ext

    task automatic close_ext();
        write_reg(3'h3, 8'h03);
    endtask : close_ext
endmodule : uprd_host_model

// File: dv/testbench.sv
// Self-checking bench of the paged channel register decoder
`timescale 1ns/10ps
`include "uprd_regs.svh"
module testbench;
    import uprd_pkg::*;
    logic clk_sys;
    logic reset;
    uprd_bus_req_type hostReq;
    uprd_status_type status;
    logic [7:0] readData;
    uprd_ctrl_type ctrlRegs;
    uprd_strobe_type strobes;
    int failures = 0;
    int checked = 0;

    uprd_decoder uprd_decoder_i (.clk_sys(clk_sys), .reset(reset), .hostReq(hostReq),
        .status(status), .readData(readData), .ctrlRegs(ctrlRegs), .strobes(strobes));
    uprd_host_model uprd_host_model_i (.clk_sys(clk_sys), .readData(readData),
        .hostReq(hostReq));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        checked++;
        if (seen !== expected) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        uprd_host_model_i.write_reg(a, d);
    endtask : wr

    task automatic rd_check(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        uprd_host_model_i.read_reg(a, v);
        check(v, e);
    endtask : rd_check

    task automatic scen_reset();
        check(8'(ctrlRegs !== '0), 8'h00);
        check(8'(strobes !== '0), 8'h00);
        check(readData, 8'h00);
    endtask : scen_reset

    task automatic scen_page_zero();
        wr(3'h3, 8'h03);
        rd_check(3'h3, 8'h03);
        wr(3'h0, 8'h5a);
        check({7'h00, strobes.txHoldingWrite}, 8'h01);
        check(strobes.data, 8'h5a);
        rd_check(3'h0, status.rxBuffer);
        check({7'h00, strobes.rxBufferRead}, 8'h01);
        wr(3'h1, 8'h0f);
        rd_check(3'h1, 8'h0f);
        wr(3'h2, 8'h07);
        check({7'h00, strobes.fifoControlWrite}, 8'h01);
        check(strobes.data, 8'h07);
        rd_check(3'h2, 8'h01);
        check({7'h00, strobes.sourceRead}, 8'h01);
        rd_check(3'h5, 8'h60);
        check({7'h00, strobes.lineStatusRead}, 8'h01);
        rd_check(3'h6, 8'h30);
        check({7'h00, strobes.modemStatusRead}, 8'h01);
        wr(3'h7, 8'h99);
        rd_check(3'h7, 8'h99);
        wr(3'h4, 8'h0b);
        rd_check(3'h4, 8'h0b);
    endtask : scen_page_zero

    task automatic scen_page_one();
        wr(3'h3, 8'h83);
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        rd_check(3'h0, 8'h34);
        rd_check(3'h1, 8'h12);
        check(ctrlRegs.interruptEnables, 8'h0f);
        rd_check(3'h4, 8'h0b);
        wr(3'h3, 8'h03);
        rd_check(3'h0, status.rxBuffer);
    endtask : scen_page_one

    task automatic scen_page_two();
        logic [3:0] f;
        wr(3'h4, 8'h40);
        wr(3'h1, 8'ha5);
        check(ctrlRegs.channelInterruptMask, 8'ha5);
        check(ctrlRegs.interruptEnables, 8'h0f);
        rd_check(3'h1, 8'h00);
        rd_check(3'h2, status.channelPending);
        rd_check(3'h5, status.txCount);
        rd_check(3'h6, status.rxCount);
        for (int k = 0; k < 2; k++) begin
            f = (k == 0) ? 4'b1010 : 4'b0101;
            @(negedge clk_sys);
            {status.txHwFlow, status.txSwFlow, status.rxHwFlow, status.rxSwFlow} = f;
            rd_check(3'h7, {2'b00, f[3:2], 2'b00, f[1:0]});
        end
        wr(3'h0, 8'hff);
        check({7'h00, strobes.txHoldingWrite}, 8'h00);
        rd_check(3'h0, 8'h00);
        rd_check(3'h4, 8'h40);
        wr(3'h4, 8'h00);
    endtask : scen_page_two

    task automatic scen_page_three();
        uprd_host_model_i.open_ext(1'b0);
        rd_check(3'h0, `UPRD_PAGE_SEL_FIXED);
        check(ctrlRegs.divisorLow, 8'h34);
        wr(3'h1, 8'hff);
        rd_check(3'h1, `UPRD_AUTO_TOGGLE_MASK);
        wr(3'h2, 8'h3c);
        rd_check(3'h2, 8'h3c);
        for (int i = 4; i < 8; i++) begin
            wr(3'(i), 8'(8'h10 + i));
        end
        check(ctrlRegs.resumeFirst, 8'h14);
        check(ctrlRegs.resumeSecond, 8'h15);
        check(ctrlRegs.pauseFirst, 8'h16);
        rd_check(3'h7, 8'h17);
        rd_check(3'h3, 8'hbf);
    endtask : scen_page_three

    task automatic scen_page_four();
        wr(3'h0, 8'h01);
        rd_check(3'h0, `UPRD_PAGE_SEL_FIXED | 8'h01);
        wr(3'h1, 8'hff);
        rd_check(3'h1, `UPRD_ADD_FEAT_MASK);
        check(ctrlRegs.autoToggle, `UPRD_AUTO_TOGGLE_MASK);
        wr(3'h2, 8'hff);
        rd_check(3'h2, `UPRD_RESEND_MASK);
        check(ctrlRegs.enhancedFeatures, 8'h3c);
        for (int i = 4; i < 8; i++) begin
            wr(3'(i), 8'(8'h20 + i));
        end
        check(ctrlRegs.txTrigger, 8'h24);
        check(ctrlRegs.rxTrigger, 8'h25);
        check(ctrlRegs.flowUpper, 8'h26);
        check(ctrlRegs.flowLower, 8'h27);
        check(ctrlRegs.pauseSecond, 8'h17);
        uprd_host_model_i.close_ext();
        rd_check(3'h3, 8'h03);
    endtask : scen_page_four

    task automatic wrap_up();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        reset = 1'b1;
        status = '{8'hc3, 8'h01, 8'h60, 8'h30, 8'h81, 8'h7e, 8'h2d, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        scen_reset();
        scen_page_zero();
        scen_page_one();
        scen_page_two();
        scen_page_three();
        scen_page_four();
        wrap_up();
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end
endmodule : testbench
